// ==== logic/dmr_bringup.sv ====
/*
 Device-side bring-up and gating of device-attached memory ranges: flag deadline,
 init mode, range sizes and bases, protocol enables and access steering.
 Assumes all inputs synchronous to ref_clk_i and a local memory that acknowledges each request.
*/
// What this block does
// - Hardware mode: both flags within one second
// - Software mode: info flag within one second
// - Hardware mode: enabled hits route to memory
// - Not ready: reads all ones, writes dropped
// - Software sets ready; hits then route locally
// - Standard BAR accesses never hit ranges
// - No I/O space ever requested or claimed
`timescale 1ns/1ps
`include "dmr_cfg.svh"
module dmr_bringup #(
   parameter int N_RANGES = `DMR_RANGES,
   parameter int ADDR_W = `DMR_ADDR_W,
   parameter int DATA_W = `DMR_DATA_W,
   parameter int DEADLINE_CYC = `DMR_FLAG_DEADLINE_CYC
) (
   // Clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   // Device-side status
   input wire logic hw_memory_init_mode_i,
   input wire logic size_known_i,
   input wire logic mem_init_done_i,
   input wire logic [N_RANGES-1:0][ADDR_W-1:0] range_size_i,
   // Host configuration writes
   input wire logic base_we_i,
   input wire logic [$clog2(N_RANGES+1)-1:0] base_sel_i,
   input wire logic base_high_i,
   input wire logic [ADDR_W/2-1:0] base_wdata_i,
   input wire logic mem_ready_set_i,
   input wire logic memory_protocol_enable_we_i,
   input wire logic memory_protocol_enable_wdata_i,
   input wire logic cache_protocol_enable_we_i,
   input wire logic cache_protocol_enable_wdata_i,
   // Host-visible status
   output logic hw_mode_o,
   output logic size_info_valid_o,
   output logic memory_ready_o,
   output logic memory_protocol_enable_o,
   output logic cache_protocol_enable_o,
   output logic [N_RANGES-1:0][ADDR_W-1:0] range_size_o,
   output logic [N_RANGES-1:0][ADDR_W-1:0] range_base_o,
   output logic io_space_request_o,
   // Incoming accesses
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic req_bar_i,
   input wire logic req_io_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   input wire logic [DATA_W-1:0] req_wdata_i,
   output logic resp_valid_o,
   output logic resp_claimed_o,
   output logic [DATA_W-1:0] resp_rdata_o,
   // Local memory
   output logic mem_req_o,
   output logic mem_write_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [DATA_W-1:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic [DATA_W-1:0] mem_rdata_i
);
   import dmr_pkg::*;

   localparam int CNT_W = $clog2(DEADLINE_CYC + 1);
   localparam int HW = ADDR_W / 2;

   typedef struct packed {
      dmr_acc_st_t st;
      logic mode_known;
      logic hw_mode;
      logic [CNT_W-1:0] cnt;
      logic info_valid;
      logic mem_ready;
      logic mem_en;
      logic cache_en;
      logic [N_RANGES-1:0][ADDR_W-1:0] base;
      logic [N_RANGES-1:0][ADDR_W-1:0] size;
      logic mem_req;
      logic mem_write;
      logic [ADDR_W-1:0] mem_addr;
      logic [DATA_W-1:0] mem_wdata;
      logic resp_valid;
      logic resp_claimed;
      logic [DATA_W-1:0] rdata;
   } dmr_state_t;

   dmr_state_t s_reg;
   dmr_state_t s_next;
   logic deadline_hit;
   logic claim;
   logic accept;

   dmr_if #(.N_RANGES(N_RANGES), .ADDR_W(ADDR_W)) lk ();

   dmr_decode #(.N_RANGES(N_RANGES), .ADDR_W(ADDR_W)) u_dec (
      .lk(lk.dec)
   );

   // Only the programmed bases are looked up, never the standard BARs
   assign lk.addr = req_addr_i;
   assign lk.base = s_reg.base;
   assign lk.size = s_reg.size;

   // Last cycle of the one-second window
   assign deadline_hit = (s_reg.cnt == CNT_W'(DEADLINE_CYC - 1));
   assign accept = clk_en_i && (s_reg.st == DMR_IDLE) && req_valid_i;
   // BAR and I/O accesses are never claimed as range traffic
   assign claim = lk.hit && s_reg.mem_en && !req_bar_i && !req_io_i;

   always_comb begin
      s_next = s_reg;
      s_next.mem_req = 1'b0;
      s_next.resp_valid = 1'b0;
      // Mode strap caught on the first enabled cycle after release
      if (!s_reg.mode_known) begin
         s_next.mode_known = 1'b1;
         s_next.hw_mode = hw_memory_init_mode_i;
      end
      // Deadline counter saturates once the window has passed
      if (s_reg.cnt != CNT_W'(DEADLINE_CYC)) begin
         s_next.cnt = s_reg.cnt + CNT_W'(1);
      end
      // Info flag forced at the deadline whatever the mode
      if (size_known_i || deadline_hit) begin
         s_next.info_valid = 1'b1;
      end
      // Sizes track the memory controller until published
      if (!s_reg.info_valid) begin
         s_next.size = range_size_i;
      end
      // Ready flag: hardware raises it in hardware mode, software in software mode
      if (s_reg.mode_known && s_reg.hw_mode) begin
         if (mem_init_done_i || deadline_hit) begin
            s_next.mem_ready = 1'b1;
         end
      end else if (s_reg.mode_known && mem_ready_set_i) begin
         s_next.mem_ready = 1'b1;
      end
      if (memory_protocol_enable_we_i) begin
         s_next.mem_en = memory_protocol_enable_wdata_i;
      end
      if (cache_protocol_enable_we_i) begin
         s_next.cache_en = cache_protocol_enable_wdata_i;
      end
      // Base halves written one at a time; out-of-range selects ignored
      if (base_we_i && (int'(base_sel_i) < N_RANGES)) begin
         if (base_high_i) begin
            s_next.base[base_sel_i][ADDR_W-1:HW] = base_wdata_i;
         end else begin
            s_next.base[base_sel_i][HW-1:0] = base_wdata_i;
         end
      end
      // Access steering
      unique case (s_reg.st)
         DMR_IDLE: begin
            if (accept) begin
               if (claim && s_reg.mem_ready) begin
                  s_next.mem_req = 1'b1;
                  s_next.mem_write = req_write_i;
                  s_next.mem_addr = lk.offset;
                  s_next.mem_wdata = req_wdata_i;
                  s_next.st = DMR_MEM_WAIT;
               end else if (claim) begin
                  // Completed locally; a write simply goes nowhere
                  s_next.resp_valid = 1'b1;
                  s_next.resp_claimed = 1'b1;
                  s_next.rdata = req_write_i ? '0 : DATA_W'(`DMR_ALL_ONES_WORD);
               end else begin
                  s_next.resp_valid = 1'b1;
                  s_next.resp_claimed = 1'b0;
                  s_next.rdata = '0;
               end
            end
         end
         DMR_MEM_WAIT: begin
            if (mem_ack_i) begin
               s_next.resp_valid = 1'b1;
               s_next.resp_claimed = 1'b1;
               s_next.rdata = s_reg.mem_write ? '0 : mem_rdata_i;
               s_next.st = DMR_IDLE;
            end
         end
      endcase
   end

   // Single state register; enable low freezes everything but reset
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         s_reg <= '0;
         s_reg.st <= DMR_IDLE;
         s_reg.info_valid <= `DMR_RST_INFO_VALID;
         s_reg.mem_ready <= `DMR_RST_MEM_READY;
         s_reg.mem_en <= `DMR_RST_MEM_EN;
         s_reg.cache_en <= `DMR_RST_CACHE_EN;
      end else if (clk_en_i) begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register; req_ready_o also gated by clk_en_i, io_space_request_o tied low
   assign hw_mode_o = s_reg.hw_mode;
   assign size_info_valid_o = s_reg.info_valid;
   assign memory_ready_o = s_reg.mem_ready;
   assign memory_protocol_enable_o = s_reg.mem_en;
   assign cache_protocol_enable_o = s_reg.cache_en;
   assign range_size_o = s_reg.size;
   assign range_base_o = s_reg.base;
   assign io_space_request_o = 1'b0;
   assign req_ready_o = clk_en_i && (s_reg.st == DMR_IDLE);
   assign resp_valid_o = s_reg.resp_valid;
   assign resp_claimed_o = s_reg.resp_claimed;
   assign resp_rdata_o = s_reg.rdata;
   assign mem_req_o = s_reg.mem_req;
   assign mem_write_o = s_reg.mem_write;
   assign mem_addr_o = s_reg.mem_addr;
   assign mem_wdata_o = s_reg.mem_wdata;
endmodule

// ==== logic/dmr_cfg.svh ====
/*
 Constants for the memory range bring-up block: timing, widths and reset values.
 Assumes inclusion by bare name from any file that needs them.
*/
`ifndef DMR_CFG_SVH
`define DMR_CFG_SVH
// Reference clock rate in Hz
`define DMR_CLK_HZ 10000000
// Longest time from reset release to the flags, in seconds
`define DMR_FLAG_DEADLINE_S 1
// Longest time rounds down to whole cycles
`define DMR_FLAG_DEADLINE_CYC (`DMR_FLAG_DEADLINE_S * `DMR_CLK_HZ)
// Default number of ranges and widths
`define DMR_RANGES 2
`define DMR_ADDR_W 64
`define DMR_DATA_W 32
// Reset values of the software-visible flags
`define DMR_RST_INFO_VALID 1'b0
`define DMR_RST_MEM_READY 1'b0
`define DMR_RST_MEM_EN 1'b0
`define DMR_RST_CACHE_EN 1'b0
// Read answer while memory is not yet ready
`define DMR_ALL_ONES_WORD 32'hFFFF_FFFF
`endif

// ==== logic/dmr_pkg.sv ====
/*
 Types for the memory range bring-up block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dmr_pkg;
   // Access sequencer states
   typedef enum logic [0:0] {
      DMR_IDLE,
      DMR_MEM_WAIT
   } dmr_acc_st_t;
endpackage

// ==== logic/dmr_if.sv ====
/*
 Carrier between the bring-up block and its range decoder.
 Assumes both ends share the parameters given at instantiation.
*/
`timescale 1ns/1ps
interface dmr_if #(
   parameter int N_RANGES = 2,
   parameter int ADDR_W = 64
);
   logic [ADDR_W-1:0] addr;
   logic [N_RANGES-1:0][ADDR_W-1:0] base;
   logic [N_RANGES-1:0][ADDR_W-1:0] size;
   logic hit;
   logic [ADDR_W-1:0] offset;
   modport dec (input addr, input base, input size, output hit, output offset);
   modport ctl (output addr, output base, output size, input hit, input offset);
endinterface

// ==== logic/dmr_decode.sv ====
/*
 Range decoder: finds the first programmed range holding an address and gives the offset.
 Assumes base and size are stable while the address is looked up; zero size means no range.
*/
`timescale 1ns/1ps
module dmr_decode #(
   parameter int N_RANGES = 2,
   parameter int ADDR_W = 64
) (
   // Lookup carrier
   dmr_if.dec lk
);
   logic [N_RANGES-1:0] in_range;
   logic [N_RANGES-1:0][ADDR_W-1:0] rel;

   // One comparator per range; the address-not-below-base check keeps the wrap case out
   for (genvar g = 0; g < N_RANGES; g++) begin : g_rng
      assign rel[g] = lk.addr - lk.base[g];
      assign in_range[g] = (lk.size[g] != '0) && (lk.addr >= lk.base[g]) && (rel[g] < lk.size[g]);
   end

   // Lowest index wins if software programs overlapping ranges
   always_comb begin
      lk.hit = 1'b0;
      lk.offset = '0;
      for (int i = N_RANGES - 1; i >= 0; i--) begin
         if (in_range[i]) begin
            lk.hit = 1'b1;
            lk.offset = rel[i];
         end
      end
   end
endmodule

// ==== test/dmr_bringup_properties.sv ====
/* Port checker for the memory range bring-up block.
 Assumes a bind onto dmr_bringup with its default widths. */
`timescale 1ns/1ps
module dmr_properties #(parameter int DEADLINE_CYC = 50) (
   // Clock, reset, inputs and req_ready_o
   input wire logic ref_clk_i, resetn_i, clk_en_i, mem_ready_set_i, mem_ack_i,
   input wire logic req_valid_i, req_ready_o, req_write_i, req_bar_i, req_io_i,
   // Outputs, plus mem_rdata_i
   input wire logic hw_mode_o, size_info_valid_o, memory_ready_o, memory_protocol_enable_o,
   input wire logic io_space_request_o, resp_valid_o, resp_claimed_o, mem_req_o,
   input wire logic [31:0] mem_rdata_i, resp_rdata_o
);
   int cnt_reg;
   logic wr_reg;
   wire tk = req_valid_i && req_ready_o;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // Enabled edges since release; saturates so it never wraps
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) cnt_reg <= 0;
      else if (clk_en_i && cnt_reg <= DEADLINE_CYC) cnt_reg <= cnt_reg + 1;
      if (tk) wr_reg <= req_write_i;
   end
   property p_info; cnt_reg >= DEADLINE_CYC |-> size_info_valid_o; endproperty
   a_info: assert property (p_info) else $error("info flag late");
   property p_hwrdy; hw_mode_o && cnt_reg >= DEADLINE_CYC |-> memory_ready_o; endproperty
   a_hwrdy: assert property (p_hwrdy) else $error("ready flag late");
   property p_swrdy; !hw_mode_o && $rose(memory_ready_o) |-> $past(mem_ready_set_i); endproperty
   a_swrdy: assert property (p_swrdy) else $error("ready set without write");
   property p_io; tk && req_io_i |=> resp_valid_o && !resp_claimed_o && !io_space_request_o; endproperty
   a_io: assert property (p_io) else $error("io access claimed");
   property p_bar; tk && req_bar_i |=> resp_valid_o && !resp_claimed_o && !mem_req_o; endproperty
   a_bar: assert property (p_bar) else $error("bar access claimed");
   property p_nrdy; tk && !memory_ready_o |=> resp_valid_o && !mem_req_o; endproperty
   a_nrdy: assert property (p_nrdy) else $error("memory used before ready");
   property p_ones; tk && !memory_ready_o && !req_write_i |=> !resp_claimed_o || resp_rdata_o == 32'hFFFF_FFFF;
   endproperty
   a_ones: assert property (p_ones) else $error("not-ready read not all ones");
   property p_off; tk && !memory_protocol_enable_o |=> resp_valid_o && !resp_claimed_o; endproperty
   a_off: assert property (p_off) else $error("claimed while disabled");
   property p_ack; mem_ack_i |=> resp_valid_o && resp_claimed_o && resp_rdata_o == (wr_reg ? 32'h0 : $past(mem_rdata_i));
   endproperty
   a_ack: assert property (p_ack) else $error("memory answer not returned");
   property p_route; tk && memory_ready_o && memory_protocol_enable_o && !req_bar_i && !req_io_i
      |=> mem_req_o || (resp_valid_o && !resp_claimed_o); endproperty
   a_route: assert property (p_route) else $error("ready hit not routed");
   c_route: cover property (mem_ack_i ##1 resp_valid_o);
   c_ones: cover property (tk && !memory_ready_o && memory_protocol_enable_o);
   c_hw: cover property (hw_mode_o && memory_ready_o);
endmodule
bind dmr_bringup dmr_properties #(.DEADLINE_CYC(DEADLINE_CYC)) dmr_properties_inst (.ref_clk_i, .resetn_i,
   .clk_en_i, .mem_ready_set_i, .mem_ack_i, .req_valid_i, .req_ready_o, .req_write_i, .req_bar_i, .req_io_i,
   .hw_mode_o, .size_info_valid_o, .memory_ready_o, .memory_protocol_enable_o, .io_space_request_o,
   .resp_valid_o, .resp_claimed_o, .mem_req_o, .mem_rdata_i, .resp_rdata_o);

// ==== test/dmr_mem_model.sv ====
/* Local memory model: 16 words, answers each request once.
 Assumes one request outstanding and byte offsets below 64. */
`timescale 1ns/1ps
module dmr_mem_model (
   // Clock and pace
   input wire logic clk_i, slow_i,
   // Request and answer
   input wire logic req_i, write_i,
   input wire logic [63:0] addr_i,
   input wire logic [31:0] wdata_i,
   output logic ack_o,
   output logic [31:0] rdata_o
);
   logic [31:0] mem_reg [16];
   logic [3:0] idx_reg;
   logic [2:0] wait_reg;
   logic busy_reg;
   initial begin
      ack_o = 0;
      busy_reg = 0;
      for (int i = 0; i < 16; i++) mem_reg[i] = 32'h5A5A_0000 + i;
   end
   // Short or long wait before the acknowledge
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      if (req_i) begin
         busy_reg <= 1'b1;
         wait_reg <= slow_i ? 3'h4 : 3'h0;
         idx_reg <= addr_i[5:2];
         if (write_i) mem_reg[addr_i[5:2]] <= wdata_i;
      end else if (busy_reg && wait_reg == 3'h0) begin
         ack_o <= 1'b1;
         busy_reg <= 1'b0;
      end else if (busy_reg) wait_reg <= wait_reg - 3'h1;
   end
   // Data is only good with the acknowledge
   assign rdata_o = ack_o ? mem_reg[idx_reg] : ~mem_reg[idx_reg];
endmodule

// ==== test/dmr_bringup_tb_top.sv ====
/* Testbench for the memory range bring-up block.
 Assumes the memory model and the bound port checker. */
`timescale 1ns/1ps
module dmr_bringup_tb_top;
   localparam int DL = 20;
   logic ref_clk_i = 0, resetn_i = 0, clk_en_i = 1, hw_memory_init_mode_i = 0, size_known_i = 0;
   logic mem_init_done_i = 1, base_we_i = 0, base_high_i = 0, mem_ready_set_i = 0, req_valid_i = 0;
   logic memory_protocol_enable_we_i = 0, memory_protocol_enable_wdata_i = 1, slow = 0;
   logic cache_protocol_enable_we_i = 0, cache_protocol_enable_wdata_i = 1, mem_ack_i;
   logic req_write_i = 0, req_bar_i = 0, req_io_i = 0, hw_mode_o, size_info_valid_o, memory_ready_o;
   logic memory_protocol_enable_o, cache_protocol_enable_o, io_space_request_o, req_ready_o;
   logic resp_valid_o, resp_claimed_o, mem_req_o, mem_write_o;
   logic [1:0] base_sel_i = 0;
   logic [31:0] base_wdata_i = 0, req_wdata_i = 0, mem_rdata_i, resp_rdata_o, mem_wdata_o;
   logic [63:0] req_addr_i = 0, mem_addr_o;
   logic [1:0][63:0] range_size_i = {64'h0000_0000_0000_0200, 64'h0000_0000_0000_0100};
   logic [1:0][63:0] range_size_o, range_base_o;
   int fail_count = 0, check_count = 0, n;
   // Free-running reference clock
   always #50 ref_clk_i = ~ref_clk_i;
   dmr_bringup #(.DEADLINE_CYC(DL)) dmr_bringup_inst (.ref_clk_i, .resetn_i, .clk_en_i, .hw_memory_init_mode_i,
      .size_known_i, .mem_init_done_i, .range_size_i, .base_we_i, .base_sel_i, .base_high_i, .base_wdata_i,
      .mem_ready_set_i, .memory_protocol_enable_we_i, .memory_protocol_enable_wdata_i, .cache_protocol_enable_we_i,
      .cache_protocol_enable_wdata_i, .hw_mode_o, .size_info_valid_o, .memory_ready_o, .memory_protocol_enable_o,
      .cache_protocol_enable_o, .range_size_o, .range_base_o, .io_space_request_o, .req_valid_i, .req_ready_o,
      .req_write_i, .req_bar_i, .req_io_i, .req_addr_i, .req_wdata_i, .resp_valid_o, .resp_claimed_o,
      .resp_rdata_o, .mem_req_o, .mem_write_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i);
   dmr_mem_model dmr_mem_model_inst (.clk_i(ref_clk_i), .slow_i(slow), .req_i(mem_req_o), .write_i(mem_write_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Inputs always move 1 ns after the edge
   task automatic step(input int k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wbase(input logic [1:0] s, input logic h, input logic [31:0] d);
      base_we_i = 1; base_sel_i = s; base_high_i = h; base_wdata_i = d;
      step(1); base_we_i = 0; step(1);
   endtask
   task automatic wen;
      memory_protocol_enable_we_i = 1; cache_protocol_enable_we_i = 1;
      step(1); memory_protocol_enable_we_i = 0; cache_protocol_enable_we_i = 0; step(1);
   endtask
   // Hold the request until taken, then wait for its answer
   task automatic acc(input logic w, b, io, input logic [63:0] a, input logic [31:0] wd, input logic c,
         input logic [31:0] rd);
      req_valid_i = 1; req_write_i = w; req_bar_i = b; req_io_i = io; req_addr_i = a; req_wdata_i = wd;
      for (n = 0; n < 50 && req_ready_o !== 1'b1; n++) step(1);
      step(1); req_valid_i = 0;
      for (n = 0; n < 50 && resp_valid_o !== 1'b1; n++) step(1);
      // A missing answer counts as a mismatch, not a silent pass
      chk(resp_valid_o, 1);
      chk(resp_claimed_o, c);
      chk(resp_rdata_o, rd);
      step(1);
   endtask
   initial begin
      step(6); resetn_i = 1;
      for (n = 0; n < DL && size_info_valid_o !== 1'b1; n++) step(1);
      chk(size_info_valid_o, 1);
      chk(memory_ready_o, 0);
      chk(range_size_o[1], 64'h0000_0000_0000_0200);
      chk(range_size_o[0], 64'h0000_0000_0000_0100);
      wbase(0, 0, 32'h0000_1000); wbase(0, 1, 32'h0000_0000); wbase(1, 0, 32'h0000_4000);
      wbase(2, 0, 32'hFFFF_FFFF);
      chk(range_base_o[0], 64'h0000_0000_0000_1000);
      chk(range_base_o[1], 64'h0000_0000_0000_4000);
      acc(0, 0, 0, 64'h1004, 0, 0, 0);
      wen();
      chk(cache_protocol_enable_o, 1);
      chk(memory_protocol_enable_o, 1);
      acc(0, 0, 0, 64'h1004, 0, 1, 32'hFFFF_FFFF);
      acc(1, 0, 0, 64'h1004, 32'h1234_5678, 1, 0);
      acc(0, 1, 0, 64'h1004, 0, 0, 0);
      acc(0, 0, 1, 64'h1004, 0, 0, 0);
      chk(io_space_request_o, 0);
      clk_en_i = 0; step(2);
      chk(req_ready_o, 0);
      clk_en_i = 1; mem_ready_set_i = 1; step(1); mem_ready_set_i = 0;
      acc(0, 0, 0, 64'h4008, 0, 1, 32'h5A5A_0002);
      acc(0, 0, 0, 64'h1004, 0, 1, 32'h5A5A_0001);
      slow = 1;
      acc(1, 0, 0, 64'h1010, 32'hDEAD_BEEF, 1, 0);
      acc(0, 0, 0, 64'h1010, 0, 1, 32'hDEAD_BEEF);
      resetn_i = 0; hw_memory_init_mode_i = 1; size_known_i = 1; mem_init_done_i = 0; step(2); resetn_i = 1;
      // Software set refused while the mode is unknown and in hardware mode
      mem_ready_set_i = 1;
      step(2);
      mem_ready_set_i = 0;
      chk(memory_ready_o, 0);
      chk(size_info_valid_o, 1);
      for (n = 2; n < DL && memory_ready_o !== 1'b1; n++) step(1);
      chk(hw_mode_o, 1);
      chk(size_info_valid_o & memory_ready_o, 1);
      wbase(0, 0, 32'h0000_1000); wen();
      acc(0, 0, 0, 64'h1004, 0, 1, 32'h5A5A_0001);
      stop_test();
   end
   // Whole run needs about a hundred cycles, far below this 3000-cycle limit
   initial begin
      #300000;
      fail_count++;
      stop_test();
   end
endmodule
